// file: core/wfd_pkg.sv
package wfd_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int SAMPLE_HZ = 200_000;
   localparam int SMP_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int MS_PER_S = 1000;
   localparam int US_PER_MS = 1000;
   localparam int TIMEOUT_MS = 100;
   localparam int TIMEOUT_CYC = (CLK_HZ / MS_PER_S) * TIMEOUT_MS;

   // ----------------------------------------------------------------
   // Geometry and scaling
   // ----------------------------------------------------------------
   localparam int NUM_COLS = 501;
   localparam int DIVS = 10;
   localparam int N_TDIV = 7;
   localparam int N_ELEM = 6;
   localparam int N_TRACE = 2 * N_ELEM;
   localparam logic [3:0] TRIG_EXT = 4'hc;
   localparam int CF_LOW = 3;
   localparam int CF_HIGH = 6;
   localparam int UNIT_PER_V = 10;
   localparam int CLIP_DV = 2000 * UNIT_PER_V;
   localparam int ZOOM_UNIT = 10;
   localparam int ZOOM_MIN = 1;
   localparam int ZOOM_MAX = 1000;
   localparam int SCR_H = 400;
   localparam int MAX_WIN = 4;
   localparam int FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int SMP_W = 16;
   localparam int COL_W = 9;
   localparam int ROW_W = 9;
   localparam int SLC_W = 20;
   localparam int XOFF_W = 24;
   localparam int REC_W = 4 + 2 + COL_W + 2 * ROW_W + 1;

   typedef enum logic [1:0] {WFD_MAP_AUTO, WFD_MAP_FIXED, WFD_MAP_USER} wfd_map_t;
   typedef enum logic {WFD_ST_ARM, WFD_ST_SWEEP} wfd_state_t;

   function automatic int wfd_tdiv_us(input int sel);
      case (sel)
         0: return 500;
         1: return 1000;
         2: return 2000;
         3: return 5000;
         4: return 10000;
         5: return 20000;
         default: return 50000;
      endcase
   endfunction

   function automatic logic [SLC_W-1:0] wfd_round_slice(input int samples);
      int s;
      s = (samples + NUM_COLS / 2) / NUM_COLS;
      if (s < 1) begin
         s = 1;
      end
      return SLC_W'(s);
   endfunction

   function automatic logic [SLC_W-1:0] wfd_tb_slice(input logic [2:0] sel,
                                                     input logic [15:0] upd_ms);
      int k;
      k = 0;
      for (int i = 0; i < N_TDIV; i++) begin
         if (i <= int'(sel) && wfd_tdiv_us(i) * DIVS <= int'(upd_ms) * US_PER_MS) begin
            k = i;
         end
      end
      return wfd_round_slice(wfd_tdiv_us(k) * DIVS * (SAMPLE_HZ / MS_PER_S) / US_PER_MS);
   endfunction

endpackage

// file: core/wfd_engine.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Record buffer
// ----------------------------------------------------------------
module wfd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         in_ready_o <= next_cnt != (AW+1)'(DEPTH);
         out_valid_o <= next_cnt != '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule // wfd_fifo

// ----------------------------------------------------------------
// Waveform capture, trigger and display engine
// ----------------------------------------------------------------
module wfd_engine import wfd_pkg::*; #(
   parameter int TMO_CYC = TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Sampled channels and external clock pin
   input wire logic signed [SMP_W-1:0] smp_volt_i [N_ELEM],
   input wire logic signed [SMP_W-1:0] smp_curr_i [N_ELEM],
   input wire logic ext_clk_i,
   // Channel setup
   input wire logic [N_ELEM-1:0] fitted_i,
   input wire logic [N_TRACE-1:0] disp_en_i,
   input wire logic [11:0] range_v_i [N_ELEM],
   input wire logic [11:0] range_i_i [N_ELEM],
   input wire logic crest6_i,
   input wire logic [9:0] zoom_i [N_TRACE],
   // Trigger and time base
   input wire logic [3:0] trig_src_i,
   input wire logic trig_fall_i,
   input wire logic signed [SMP_W-1:0] trig_level_i,
   input wire logic trig_normal_i,
   input wire logic harm_mode_i,
   input wire logic [19:0] harm_win_smp_i,
   input wire logic [2:0] tdiv_sel_i,
   input wire logic [15:0] upd_ms_i,
   // Window layout
   input wire logic [2:0] nwin_i,
   input wire wfd_map_t map_mode_i,
   input wire logic [1:0] user_win_i [N_TRACE],
   input wire logic interp_i,
   // Cursors
   input wire logic [3:0] cur_trace_i,
   input wire logic [COL_W-1:0] cur_x1_i,
   input wire logic [COL_W-1:0] cur_x2_i,
   output logic signed [SMP_W-1:0] cur_y1_o,
   output logic signed [SMP_W-1:0] cur_y2_o,
   output logic signed [SMP_W:0] cur_dy_o,
   output logic [XOFF_W-1:0] cur_x1_off_o,
   output logic [XOFF_W-1:0] cur_x2_off_o,
   output logic signed [XOFF_W:0] cur_dx_o,
   // Column records to the display
   output logic col_valid_o,
   input wire logic col_ready_i,
   output logic [REC_W-1:0] col_rec_o,
   // Status
   output logic armed_o,
   output logic frame_done_o,
   output logic overrun_o
);
   localparam logic [7:0] SMP_LAST = 8'(SMP_DIV - 1);
   localparam logic [COL_W-1:0] COL_LAST = COL_W'(NUM_COLS - 1);

   logic ext_s1, ext_s2, prev_hi, src_hi, trig_hit, force_to, go, go_trig, take;
   logic first, col_end, last_col, smp_tick, emit_busy, emit_adv, fifo_ready;
   logic [7:0] smp_cnt;
   logic [31:0] tmo_cnt;
   wfd_state_t state;
   logic signed [SMP_W-1:0] trc [N_TRACE];
   logic signed [SMP_W-1:0] trc_c [N_TRACE];
   logic [19:0] fs [N_TRACE];
   logic [N_TRACE-1:0] trc_en;
   logic signed [SMP_W-1:0] acc_max [N_TRACE];
   logic signed [SMP_W-1:0] acc_min [N_TRACE];
   logic signed [SMP_W-1:0] next_max [N_TRACE];
   logic signed [SMP_W-1:0] next_min [N_TRACE];
   logic signed [SMP_W-1:0] snap_max [N_TRACE];
   logic signed [SMP_W-1:0] snap_min [N_TRACE];
   logic [SLC_W-1:0] smp_in_col, slice_q, slice_now, slice_eff;
   logic [COL_W-1:0] col_idx, emit_col;
   logic [3:0] emit_idx;
   logic [1:0] rec_win;
   logic [ROW_W-1:0] rec_top, rec_bot;
   logic [REC_W-1:0] rec;
   logic signed [SMP_W-1:0] cur_mem [NUM_COLS];
   logic [NUM_COLS-1:0] cur_ok;

   function automatic logic [ROW_W-1:0] wfd_row(input logic signed [SMP_W-1:0] v,
                                                input logic [9:0] zoom, input logic [19:0] f,
                                                input int half, input int center);
      longint y;
      y = (longint'(v) * longint'(zoom) * half) / (longint'(f) * ZOOM_UNIT);
      if (y > half) begin
         y = half;
      end else if (y < -half) begin
         y = -half;
      end
      return ROW_W'(longint'(center) - y);
   endfunction

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
      end else begin
         ext_s1 <= ext_clk_i;
         ext_s2 <= ext_s1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         smp_cnt <= '0;
         smp_tick <= 1'b0;
      end else begin
         smp_tick <= smp_cnt == SMP_LAST;
         smp_cnt <= (smp_cnt == SMP_LAST) ? '0 : smp_cnt + 8'h01;
      end
   end

   always_comb begin
      int vv;
      int ff;
      vv = 0;
      ff = 0;
      for (int t = 0; t < N_TRACE; t++) begin
         trc[t] = t[0] ? smp_curr_i[t/2] : smp_volt_i[t/2];
         ff = int'(t[0] ? range_i_i[t/2] : range_v_i[t/2]) *
              (crest6_i ? CF_HIGH : CF_LOW) * UNIT_PER_V;
         if (!t[0] && ff > CLIP_DV) begin
            ff = CLIP_DV;
         end
         if (ff < 1) begin
            ff = 1;
         end
         fs[t] = 20'(ff);
         vv = int'(trc[t]);
         if (vv > ff) begin
            vv = ff;
         end else if (vv < -ff) begin
            vv = -ff;
         end
         trc_c[t] = SMP_W'(vv);
         trc_en[t] = disp_en_i[t] & fitted_i[t/2];
      end
   end

   // ----------------------------------------------------------------
   // Trigger
   // ----------------------------------------------------------------
   always_comb begin
      if (trig_src_i == TRIG_EXT) begin
         src_hi = ext_s2;
      end else if (int'(trig_src_i) < N_TRACE) begin
         src_hi = trc[trig_src_i] >= trig_level_i;
      end else begin
         src_hi = 1'b0;
      end
   end

   assign trig_hit = smp_tick & (trig_fall_i ? (prev_hi & ~src_hi) : (~prev_hi & src_hi));
   assign force_to = ~trig_normal_i & (tmo_cnt >= 32'(TMO_CYC - 1));
   assign go_trig = (state == WFD_ST_ARM) & trig_hit;
   assign go = go_trig | ((state == WFD_ST_ARM) & force_to);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_hi <= 1'b0;
      end else if (smp_tick) begin
         prev_hi <= src_hi;
      end
   end

   // ----------------------------------------------------------------
   // Sweep control
   // ----------------------------------------------------------------
   // 1-2-5 time base, harmonic span, slice size
   assign slice_now = harm_mode_i ? wfd_round_slice(int'(harm_win_smp_i))
                                  : wfd_tb_slice(tdiv_sel_i, upd_ms_i);
   assign slice_eff = (state == WFD_ST_ARM) ? slice_now : slice_q;
   assign take = smp_tick & ((state == WFD_ST_SWEEP) | go_trig);
   assign first = smp_in_col == '0;
   assign col_end = take & (smp_in_col == slice_eff - SLC_W'(1));
   assign last_col = col_idx == COL_LAST;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= WFD_ST_ARM;
         armed_o <= 1'b1;
      end else if (state == WFD_ST_ARM && go) begin
         state <= WFD_ST_SWEEP;
         armed_o <= 1'b0;
      end else if (state == WFD_ST_SWEEP && col_end && last_col) begin
         state <= WFD_ST_ARM;
         armed_o <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tmo_cnt <= '0;
      end else if (state != WFD_ST_ARM || go || trig_normal_i) begin
         tmo_cnt <= '0;
      end else begin
         tmo_cnt <= tmo_cnt + 32'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         slice_q <= SLC_W'(1);
         smp_in_col <= '0;
         col_idx <= '0;
         frame_done_o <= 1'b0;
         overrun_o <= 1'b0;
      end else begin
         frame_done_o <= col_end & last_col;
         if (go) begin
            slice_q <= slice_now;
         end
         if (col_end && emit_busy) begin
            overrun_o <= 1'b1;
         end else if (go) begin
            overrun_o <= 1'b0;
         end
         if (take) begin
            smp_in_col <= col_end ? '0 : smp_in_col + SLC_W'(1);
            if (col_end) begin
               col_idx <= last_col ? '0 : col_idx + COL_W'(1);
            end
         end
      end
   end

   always_comb begin
      for (int t = 0; t < N_TRACE; t++) begin
         next_max[t] = (first || trc_c[t] > acc_max[t]) ? trc_c[t] : acc_max[t];
         next_min[t] = (first || trc_c[t] < acc_min[t]) ? trc_c[t] : acc_min[t];
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int t = 0; t < N_TRACE; t++) begin
            acc_max[t] <= '0;
            acc_min[t] <= '0;
            snap_max[t] <= '0;
            snap_min[t] <= '0;
         end
      end else if (take) begin
         for (int t = 0; t < N_TRACE; t++) begin
            acc_max[t] <= next_max[t];
            acc_min[t] <= next_min[t];
            if (col_end) begin
               snap_max[t] <= next_max[t];
               snap_min[t] <= next_min[t];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Record emitter
   // ----------------------------------------------------------------
   assign emit_adv = emit_busy & (~trc_en[emit_idx] | fifo_ready);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         emit_busy <= 1'b0;
         emit_idx <= '0;
         emit_col <= '0;
      end else if (col_end) begin
         emit_busy <= 1'b1;
         emit_idx <= '0;
         emit_col <= col_idx;
      end else if (emit_adv) begin
         emit_idx <= emit_idx + 4'h1;
         emit_busy <= int'(emit_idx) != N_TRACE - 1;
      end
   end

   always_comb begin
      int nw;
      int slot;
      int half;
      int zm;
      int ti;
      nw = int'(nwin_i);
      slot = 0;
      ti = (int'(emit_idx) < N_TRACE) ? int'(emit_idx) : 0;
      if (nw < 1) begin
         nw = 1;
      end else if (nw > MAX_WIN) begin
         nw = MAX_WIN;
      end
      case (map_mode_i)
         WFD_MAP_AUTO: begin
            for (int t = 0; t < N_TRACE; t++) begin
               if (t < ti && trc_en[t]) begin
                  slot = slot + 1;
               end
            end
         end
         WFD_MAP_USER: slot = int'(user_win_i[ti]);
         default: slot = ti;
      endcase
      slot = slot % nw;
      rec_win = 2'(slot);
      half = SCR_H / (2 * nw);
      zm = int'(zoom_i[ti]);
      if (zm < ZOOM_MIN) begin
         zm = ZOOM_MIN;
      end else if (zm > ZOOM_MAX) begin
         zm = ZOOM_MAX;
      end
      rec_top = wfd_row(snap_max[ti], 10'(zm), fs[ti], half, (2 * slot + 1) * half);
      rec_bot = wfd_row(snap_min[ti], 10'(zm), fs[ti], half, (2 * slot + 1) * half);
   end

   // interpolation flag travels with each point pair
   assign rec = {emit_idx, rec_win, emit_col, rec_top, rec_bot, interp_i};

   wfd_fifo #(
      .W(REC_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(mclk_i),
      .nrst_i(nrst_i),
      .in_valid_i(emit_busy & trc_en[emit_idx]),
      .in_data_i(rec),
      .in_ready_o(fifo_ready),
      .out_valid_o(col_valid_o),
      .out_data_o(col_rec_o),
      .out_ready_i(col_ready_i)
   );

   // ----------------------------------------------------------------
   // Cursor readout
   // ----------------------------------------------------------------
   // cursors read compressed column data
   always_ff @(posedge mclk_i) begin
      if (col_end && int'(cur_trace_i) < N_TRACE) begin
         cur_mem[col_idx] <= next_max[cur_trace_i];
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur_ok <= '0;
      end else if (col_end) begin
         cur_ok[col_idx] <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur_y1_o <= '0;
         cur_y2_o <= '0;
         cur_dy_o <= '0;
         cur_x1_off_o <= '0;
         cur_x2_off_o <= '0;
         cur_dx_o <= '0;
      end else begin
         cur_y1_o <= (cur_x1_i <= COL_LAST && cur_ok[cur_x1_i]) ? cur_mem[cur_x1_i] : '0;
         cur_y2_o <= (cur_x2_i <= COL_LAST && cur_ok[cur_x2_i]) ? cur_mem[cur_x2_i] : '0;
         cur_dy_o <= (SMP_W+1)'(cur_y2_o) - (SMP_W+1)'(cur_y1_o);
         cur_x1_off_o <= XOFF_W'(cur_x1_i) * XOFF_W'(slice_q);
         cur_x2_off_o <= XOFF_W'(cur_x2_i) * XOFF_W'(slice_q);
         cur_dx_o <= (XOFF_W+1)'(cur_x2_off_o) - (XOFF_W+1)'(cur_x1_off_o);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_frame_cols:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         frame_done_o |-> $past(col_idx) == COL_LAST && col_idx == '0)
      else $error("Frame ended away from the last column.");

   a_row_order:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         (emit_busy && trc_en[emit_idx]) |-> rec_top <= rec_bot)
      else $error("Maximum drawn below minimum.");

   a_sample_period:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         smp_tick |=> !smp_tick ##124 smp_tick)
      else $error("Sample period is not 125 cycles.");

   a_trig_start:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         (state == WFD_ST_ARM && trig_hit) |=> state == WFD_ST_SWEEP)
      else $error("Trigger did not start a sweep.");

   a_auto_bound:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         !trig_normal_i |-> tmo_cnt <= 32'(TMO_CYC - 1))
      else $error("Auto timeout overran.");

   a_normal_hold:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         (trig_normal_i && state == WFD_ST_ARM && !trig_hit) |=> state == WFD_ST_ARM)
      else $error("Normal mode swept without trigger.");

   a_trig_left:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         go_trig |-> col_idx == '0 && smp_in_col == '0)
      else $error("Trigger sample not in first column.");

   a_clip_span:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         (emit_busy && !emit_idx[0]) |->
            int'(snap_max[emit_idx]) <= CLIP_DV && int'(snap_min[emit_idx]) >= -CLIP_DV)
      else $error("Voltage beyond clip span.");

   a_tmo_restart:
      assert property (@(posedge mclk_i) disable iff (!nrst_i)
         (state == WFD_ST_SWEEP) |-> tmo_cnt == '0)
      else $error("Timeout not restarted.");

endmodule // wfd_engine

// file: tb/wfd_scope_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Sampled channels and raster display
// ----------------------------------------------------------------
module wfd_scope_model import wfd_pkg::*; (
   // Clock and stimulus
   input wire logic mclk_i,
   input wire logic step_i,
   // Channels
   output logic signed [SMP_W-1:0] smp_volt_o [N_ELEM],
   output logic signed [SMP_W-1:0] smp_curr_o [N_ELEM],
   // Display side
   output logic col_ready_o
);
   logic [1:0] phase = 2'h0;
   initial begin
      col_ready_o = 1'b0;
      smp_volt_o = '{default: '0};
      smp_curr_o = '{default: '0};
   end
   always @(posedge mclk_i) begin
      phase <= #1 (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      col_ready_o <= #1 (phase == 2'h0);
      smp_volt_o[0] <= #1 step_i ? 16'sh01f4 : 16'sh0000;
      smp_curr_o[0] <= #1 step_i ? 16'shfe0c : 16'sh0000;
   end
endmodule // wfd_scope_model

// file: tb/wfd_engine_tb_top.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Engine testbench
// ----------------------------------------------------------------
module wfd_engine_tb_top import wfd_pkg::*; ;
   localparam int TMO = 2000;
   localparam int LIMIT = 90000;
   localparam int ROW = 200 - (500 * 20 * 200) / (300 * 3 * 10 * 10 / 3);
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic step = 1'b0;
   logic trig_normal = 1'b1;
   logic [COL_W-1:0] x1 = 9'h000;
   logic [COL_W-1:0] x2 = 9'h000;
   logic ready;
   logic [N_TRACE-1:0] disp_en = 12'h001;
   logic crest6 = 1'b0;
   logic [3:0] trig_src = 4'h0;
   logic trig_fall = 1'b0;
   logic signed [SMP_W-1:0] trig_level = 16'sh0064;
   logic harm_mode = 1'b1;
   logic [2:0] nwin = 3'h1;
   wfd_map_t map_mode = WFD_MAP_AUTO;
   logic interp = 1'b1;
   logic [3:0] cur_trace = 4'h0;
   logic [5:0] exp_tw = 6'h00;
   logic [ROW_W-1:0] exp_row = ROW_W'(ROW);
   logic exp_lin = 1'b1;
   logic signed [SMP_W-1:0] volt [N_ELEM];
   logic signed [SMP_W-1:0] curr [N_ELEM];
   logic [11:0] rng [N_ELEM] = '{default: 12'h064};
   logic [9:0] zoom [N_TRACE] = '{default: 10'h014};
   logic [1:0] uwin [N_TRACE] = '{default: 2'h0};
   logic signed [SMP_W-1:0] y1, y2;
   logic signed [SMP_W:0] dy;
   logic [XOFF_W-1:0] x1off, x2off;
   logic signed [XOFF_W:0] dx;
   logic cval, armed, fdone, ovr;
   logic [REC_W-1:0] rec;
   int err_total = 0;
   int tests_run = 0;
   int n_rec = 0;
   int cyc = 0;

   always #20 mclk_i = ~mclk_i;

   wfd_scope_model u_far (.mclk_i(mclk_i), .step_i(step), .smp_volt_o(volt),
      .smp_curr_o(curr), .col_ready_o(ready));

   wfd_engine #(.TMO_CYC(TMO)) u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .smp_volt_i(volt), .smp_curr_i(curr), .ext_clk_i(1'b0), .fitted_i(6'h3f),
      .disp_en_i(disp_en), .range_v_i(rng), .range_i_i(rng), .crest6_i(crest6),
      .zoom_i(zoom), .trig_src_i(trig_src), .trig_fall_i(trig_fall), .trig_level_i(trig_level),
      .trig_normal_i(trig_normal), .harm_mode_i(harm_mode), .harm_win_smp_i(20'h001f5),
      .tdiv_sel_i(3'h0), .upd_ms_i(16'h01f4), .nwin_i(nwin), .map_mode_i(map_mode),
      .user_win_i(uwin), .interp_i(interp), .cur_trace_i(cur_trace), .cur_x1_i(x1),
      .cur_x2_i(x2), .cur_y1_o(y1), .cur_y2_o(y2), .cur_dy_o(dy), .cur_x1_off_o(x1off),
      .cur_x2_off_o(x2off), .cur_dx_o(dx), .col_valid_o(cval), .col_ready_i(ready),
      .col_rec_o(rec), .armed_o(armed), .frame_done_o(fdone), .overrun_o(ovr));

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic wait_armed(input logic v, input int n);
      for (int i = 0; i < n && armed !== v; i++) begin
         tick(1);
      end
      chk(armed, v);
   endtask

   always @(negedge mclk_i) begin
      cyc <= cyc + 1;
      if (cval && ready) begin
         chk(rec, {exp_tw, COL_W'(n_rec % NUM_COLS), exp_row, exp_row, exp_lin});
         n_rec++;
      end
      if (cyc == LIMIT) begin
         err_total++;
         finish_test();
      end
   end

   initial begin
      tick(10);
      nrst_i = 1'b1;
      tick(3000);
      chk({armed, 32'(n_rec)}, {1'b1, 32'h0});
      trig_normal = 1'b0;
      wait_armed(1'b0, TMO + 300);
      nrst_i = 1'b0;
      trig_normal = 1'b1;
      tick(2);
      nrst_i = 1'b1;
      tick(300);
      step = 1'b1;
      wait_armed(1'b0, 300);
      for (int i = 0; i < 70000 && fdone !== 1'b1; i++) begin
         tick(1);
      end
      chk({fdone, armed}, 2'h3);
      tick(20);
      chk({ovr, 32'(n_rec)}, {1'b0, 32'd501});
      x2 = 9'h1f4;
      tick(3);
      chk({y1, y2, dy}, {16'sh01f4, 16'sh01f4, 17'sh0});
      chk({x1off, x2off, dx}, {24'h0, 24'h1f4, 25'sh1f4});
      x2 = 9'h1f5;
      tick(3);
      chk(y2, 16'sh0);
      tick(3000);
      chk(armed, 1'b1);
      step = 1'b0;
      tick(300);
      trig_src = 4'h1;
      trig_fall = 1'b1;
      trig_level = 16'shff9c;
      disp_en = 12'h002;
      crest6 = 1'b1;
      harm_mode = 1'b0;
      nwin = 3'h2;
      map_mode = WFD_MAP_FIXED;
      interp = 1'b0;
      cur_trace = 4'h1;
      exp_tw = 6'h05;
      exp_row = 9'h13c;
      exp_lin = 1'b0;
      tick(300);
      step = 1'b1;
      wait_armed(1'b0, 300);
      tick(400);
      chk({ovr, 32'(n_rec)}, {1'b0, 32'd503});
      chk(y1, 16'shfe0c);
      chk({x1off, x2off}, {24'h0, 24'h3ea});
      finish_test();
   end
endmodule // wfd_engine_tb_top
